// *** verilog/timer_one.sv ***
// 16-bit timer/counter with control, count and flag registers on Avalon-MM.
// Assumes external clock pins are asynchronous to clk; the core clock is
// the oscillator, so the instruction clock is clk divided by four.
`default_nettype none
module timer_one
  import timer_one_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  input  wire logic        ext_count_clock_pin,
  input  wire logic        osc_input_pin,
  input  wire logic        sleep_mode,
  input  wire logic        compare_one_reset,
  input  wire logic        compare_two_reset,
  input  wire logic [1:0]  port_direction_setting,
  input  wire logic [1:0]  port_out_value,
  output logic             osc_inverter_on,
  output logic             osc_input_pin_oe,
  output logic             osc_input_pin_out,
  output logic             osc_output_pin_oe,
  output logic             osc_output_pin_out,
  output logic             overflow_irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0]    control_q;
  logic [15:0]   count_q;
  logic          overflow_flag_q;
  logic          overflow_irq_enable_q;
  logic [1:0]    instr_div_q;
  logic          ext_prev_q;
  logic          armed_q;
  logic          on_prev_q;
  logic          ccp_s1_q;
  logic          ccp_s2_q;
  logic [1:0]    pin_s1_q;
  logic [1:0]    pin_s2_q;
  bus_state_type bus_state_q;
  logic [7:0]    addr_q;
  logic [31:0]   readdata_q;

  logic counter_on;
  logic clock_source_select;
  logic sync_disable;
  logic osc_enable;
  logic [1:0] prescale_select;
  assign counter_on          = control_q[ON_BIT];
  assign clock_source_select = control_q[CS_BIT];
  assign sync_disable        = control_q[SYNC_BIT];
  assign osc_enable          = control_q[OSC_BIT];
  assign prescale_select     = control_q[PS_HI:PS_LO];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic wr_flags;
  // A write lands at the edge where waitrequest is sampled low
  assign wr_en    = write && bus_state_q == ACK_ST && byteenable[0];
  assign wr_ctrl  = wr_en && address == CONTROL_OFFSET;
  assign wr_lo    = wr_en && address == COUNT_LO_OFFSET;
  assign wr_hi    = wr_en && address == COUNT_HI_OFFSET;
  assign wr_flags = wr_en && address == FLAGS_OFFSET;

  // ----------------------------------------------------------------
  // Input synchronizers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ccp_s1_q <= 1'b0;
      ccp_s2_q <= 1'b0;
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
    end else begin
      ccp_s1_q <= compare_one_reset || compare_two_reset;
      ccp_s2_q <= ccp_s1_q;
      pin_s1_q <= {osc_input_pin, ext_count_clock_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Source picked after the synchronizers; a raw pin mux could glitch
  logic ext_sync;
  assign ext_sync = osc_enable ? pin_s2_q[1] : pin_s2_q[0];

  // Idle level of both pins is low, so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_sync;
    end
  end

  logic ext_rise;
  logic ext_fall;
  assign ext_rise = ext_sync && !ext_prev_q;
  assign ext_fall = !ext_sync && ext_prev_q;

  // ----------------------------------------------------------------
  // Clock source and arming
  // ----------------------------------------------------------------
  // instruction clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_div_q <= 2'b00;
    end else begin
      instr_div_q <= (instr_div_q == INSTR_DIV_LAST) ? 2'b00 : instr_div_q + 2'b01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_prev_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      on_prev_q <= counter_on && clock_source_select;
      if (!(counter_on && clock_source_select)) begin
        armed_q <= 1'b0;
      end else if (!on_prev_q) begin
        armed_q <= 1'b0;
      end else if (ext_fall) begin
        armed_q <= 1'b1;
      end
    end
  end

  logic src_tick;
  assign src_tick = clock_source_select ? (ext_rise && armed_q)
                                        : (instr_div_q == INSTR_DIV_LAST);

  logic pre_tick;
  prescale_divider u_prescale (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (wr_lo || wr_hi),
    .tick_in  (src_tick && counter_on),
    .select   (prescale_select),
    .tick_out (pre_tick)
  );

  // sync path stops in sleep; async path keeps counting
  logic inc;
  assign inc = pre_tick &&
               (!clock_source_select || sync_disable || !sleep_mode);

  // compare reset, not in unsynchronized counter mode
  logic ccp_clear;
  assign ccp_clear = ccp_s2_q && !(clock_source_select && sync_disable);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // 16-bit count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 16'h0000;
    end else if (wr_lo) begin
      count_q[7:0] <= writedata[7:0];
    end else if (wr_hi) begin
      count_q[15:8] <= writedata[7:0];
    end else if (ccp_clear) begin
      count_q <= 16'h0000;
    end else if (inc) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Overflow and control
  // ----------------------------------------------------------------
  // Compare reset beats a wrap, so it never sets the flag
  logic wrap;
  assign wrap = inc && count_q == COUNT_MAX && !wr_lo && !wr_hi && !ccp_clear;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_q       <= 1'b0;
      overflow_irq_enable_q <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag_q <= 1'b1;
      end else if (wr_flags) begin
        overflow_flag_q <= writedata[FLAG_BIT];
      end
      if (wr_flags) begin
        overflow_irq_enable_q <= writedata[IE_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_q <= CONTROL_RESET[5:0];
    end else if (wr_ctrl) begin
      control_q <= writedata[5:0] & CONTROL_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      CONTROL_OFFSET:  v = {26'h0, control_q};
      COUNT_LO_OFFSET: v = {24'h0, count_q[7:0]};
      COUNT_HI_OFFSET: v = {24'h0, count_q[15:8]};
      FLAGS_OFFSET:    v = {30'h0, overflow_irq_enable_q, overflow_flag_q};
      // pins read zero with oscillator on
      PIN_OFFSET:      v = osc_enable ? 32'h0 : {30'h0, pin_s2_q};
      default:         v = 32'h0000_0000;
    endcase
    return v;
  endfunction : read_mux

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_q <= IDLE_ST;
      addr_q      <= 8'h00;
      readdata_q  <= 32'h0000_0000;
    end else begin
      case (bus_state_q)
        // Writes share the read path, so waitrequest can come from a flop
        IDLE_ST: begin
          if (read || write) begin
            addr_q      <= address;
            bus_state_q <= READ_ST;
          end
        end
        READ_ST: begin
          readdata_q  <= read_mux(addr_q);
          bus_state_q <= ACK_ST;
        end
        ACK_ST:  bus_state_q <= IDLE_ST;
        default: bus_state_q <= IDLE_ST;
      endcase
    end
  end

  // Every request waits two cycles; low only while the state is ACK_ST
  logic wait_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= !(bus_state_q == READ_ST);
    end
  end

  assign readdata    = readdata_q;
  assign waitrequest = wait_q;

  // ----------------------------------------------------------------
  // Pins and interrupt
  // ----------------------------------------------------------------
  logic       osc_on_q;
  logic [1:0] pin_oe_q;
  logic [1:0] pin_out_q;
  logic       irq_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_on_q <= 1'b0;
    end else begin
      osc_on_q <= osc_enable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_q  <= 2'b00;
      pin_out_q <= 2'b00;
    end else begin
      pin_oe_q  <= osc_enable ? 2'b00 : ~port_direction_setting;
      pin_out_q <= port_out_value;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (overflow_flag_q || wrap) && overflow_irq_enable_q;
    end
  end

  assign osc_inverter_on    = osc_on_q;
  assign osc_input_pin_oe   = pin_oe_q[1];
  assign osc_input_pin_out  = pin_out_q[1];
  assign osc_output_pin_oe  = pin_oe_q[0];
  assign osc_output_pin_out = pin_out_q[0];
  assign overflow_irq       = irq_q;
endmodule : timer_one
`default_nettype wire

// *** include/timer_one_pkg.sv ***
// Package for the 16-bit timer/counter: register offsets, field positions,
// reset values and timing counts.
// Assumes a 10 MHz core clock and a 32-bit Avalon-MM register port.
`default_nettype none
package timer_one_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET  = 8'h10;
  localparam logic [7:0] COUNT_LO_OFFSET = 8'h14;
  localparam logic [7:0] COUNT_HI_OFFSET = 8'h18;
  localparam logic [7:0] FLAGS_OFFSET    = 8'h1c;
  localparam logic [7:0] PIN_OFFSET      = 8'h20;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int ON_BIT   = 0;
  localparam int CS_BIT   = 1;
  localparam int SYNC_BIT = 2;
  localparam int OSC_BIT  = 3;
  localparam int PS_LO    = 4;
  localparam int PS_HI    = 5;
  localparam logic [5:0] CONTROL_WMASK = 6'h3f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  // Flags register fields
  localparam int FLAG_BIT = 0;
  localparam int IE_BIT   = 1;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int OSC_DIV         = 4;
  localparam int INSTR_HZ        = CLK_HZ / OSC_DIV;
  localparam int INSTR_CYCLES    = CLK_HZ / INSTR_HZ;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CYCLES - 1);
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  typedef enum logic [1:0] {
    IDLE_ST = 2'b00,
    READ_ST = 2'b01,
    ACK_ST  = 2'b11
  } bus_state_type;
endpackage : timer_one_pkg
`default_nettype wire

// *** verilog/prescale_divider.sv ***
// Two-bit-field prescaler: divides a one-cycle tick by 1, 2, 4 or 8.
// Assumes tick_in is a single-cycle pulse on clk.
`default_nettype none
module prescale_divider
  import timer_one_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [1:0] select,
  output logic            tick_out
);
  logic [2:0] count_q;
  logic [2:0] last;

  always_comb begin
    case (select)
      2'b00:   last = 3'h0;
      2'b01:   last = 3'h1;
      2'b10:   last = 3'h3;
      default: last = 3'h7;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 3'h0;
    end else if (clear) begin
      count_q <= 3'h0;
    end else if (tick_in) begin
      count_q <= (count_q >= last) ? 3'h0 : count_q + 3'h1;
    end
  end

  assign tick_out = tick_in && !clear && (count_q >= last);
endmodule : prescale_divider
`default_nettype wire

// *** verification/count_clock_source.sv ***
// Model of the external count clock and the watch crystal input.
// Assumes calls start on a clk edge; both pins idle low between bursts.
`default_nettype none
module count_clock_source (
  input  wire logic clk,
  output logic      ext_pin,
  output logic      osc_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Pin drive
  // ------------------------------
  initial begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // Starts low, so the first rise comes before arming and is not counted
  task automatic pulse(input int n, input bit use_osc);
    repeat (n) begin
      repeat (4) @(posedge clk);
      if (use_osc) begin
        osc_pin <= 1'b1;
      end else begin
        ext_pin <= 1'b1;
      end
      repeat (4) @(posedge clk);
      osc_pin <= 1'b0;
      ext_pin <= 1'b0;
    end
  endtask : pulse
  // Parks the pin that is not counting, so the readback has a level to hide
  task automatic hold_idle_pin(input bit use_osc, input bit lvl);
    if (use_osc) begin
      ext_pin <= lvl;
    end else begin
      osc_pin <= lvl;
    end
  endtask : hold_idle_pin
endmodule : count_clock_source
`default_nettype wire

// *** verification/timer_one_monitor.sv ***
// Assertions on the timer_one ports.
// Assumes one clock domain and the package register offsets.
`default_nettype none
module timer_one_monitor
  import timer_one_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  port_direction_setting,
  input wire logic        osc_inverter_on,
  input wire logic        osc_input_pin_oe,
  input wire logic        osc_output_pin_oe,
  input wire logic        overflow_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Port relations
  // ------------------------------
  logic rd_done;
  assign rd_done = read && !waitrequest;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_write_bounded: assert property ($rose(write) |-> ##[1:4] !waitrequest)
    else $error("write not answered");
  chk_read_bounded: assert property ($rose(read) |-> ##[1:4] !waitrequest)
    else $error("read not answered");
  chk_ctrl_upper: assert property (rd_done && address == CONTROL_OFFSET
    |-> readdata[31:6] == 26'h0) else $error("control upper bits set");
  chk_unmapped_zero: assert property (rd_done && address == 8'h04
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  chk_pin_zero: assert property (rd_done && address == PIN_OFFSET && osc_inverter_on
    |-> readdata[1:0] == 2'h0) else $error("pins not zero with oscillator on");
  chk_osc_inputs: assert property (osc_inverter_on
    |-> !osc_input_pin_oe && !osc_output_pin_oe) else $error("pin driven with oscillator on");
  chk_dir_follow: assert property ($past(rst_n) && !osc_inverter_on
    && $past(!osc_inverter_on) && $stable(port_direction_setting)
    |-> osc_input_pin_oe == !port_direction_setting[1]) else $error("direction ignored");
  chk_irq_falls: assert property ($fell(overflow_irq)
    |-> $past(write) || $past(write, 2)) else $error("irq dropped alone");
  chk_flags_irq: assert property (rd_done && address == FLAGS_OFFSET
    && $stable(overflow_irq) |-> overflow_irq == &readdata[1:0])
    else $error("irq differs from flag and enable");
endmodule : timer_one_monitor
bind timer_one timer_one_monitor i_mon (.clk(clk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .port_direction_setting(port_direction_setting), .osc_inverter_on(osc_inverter_on),
  .osc_input_pin_oe(osc_input_pin_oe), .osc_output_pin_oe(osc_output_pin_oe),
  .overflow_irq(overflow_irq));
`default_nettype wire

// *** verification/timer_one_tb.sv ***
// Self-checking bench for timer_one: registers, rates, counting, overflow.
// Assumes the package, the monitor bind and the clock source model.
`default_nettype none
module timer_one_tb
  import timer_one_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------
  // Signals and models
  // ------------------------------
  logic        clk, rst_n, read, write, sleep_mode, cmp_one, cmp_two;
  logic        waitrequest, irq, ext_pin, osc_pin;
  logic [7:0]  address;
  logic [1:0]  dir, pout;
  wire         osc_on;
  wire [1:0]   pin_oe, pin_out;
  logic [31:0] writedata, readdata, rd_val, base, v;
  logic [31:0] exp_q[$], msk_q[$];
  int          fails = 0, n_tests = 0, cyc = 0, s1;
  logic [7:0]  c_ctl[5] = '{8'h03, 8'h37, 8'h13, 8'h03, 8'h0b};
  int          c_n[5] = '{5, 17, 5, 5, 5};
  logic [7:0]  c_exp[5] = '{8'h04, 8'h02, 8'h02, 8'h00, 8'h04};
  logic        c_slp[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  timer_one i_dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
    .waitrequest(waitrequest), .ext_count_clock_pin(ext_pin), .osc_input_pin(osc_pin),
    .sleep_mode(sleep_mode), .compare_one_reset(cmp_one), .compare_two_reset(cmp_two),
    .port_direction_setting(dir), .port_out_value(pout), .osc_inverter_on(osc_on),
    .osc_input_pin_oe(pin_oe[1]), .osc_input_pin_out(pin_out[1]),
    .osc_output_pin_oe(pin_oe[0]), .osc_output_pin_out(pin_out[0]), .overflow_irq(irq)
  );
  count_clock_source i_src (.clk(clk), .ext_pin(ext_pin), .osc_pin(osc_pin));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // ------------------------------
  // Bus tasks and checking
  // ------------------------------
  task automatic compare(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : compare
  // Request holds until waitrequest is sampled low at a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    write <= 1'b1;
    address <= a;
    writedata <= d;
    do @(posedge clk); while (waitrequest);
    write <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    read <= 1'b1;
    address <= a;
    do @(posedge clk); while (waitrequest);
    rd_val = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask : rd_chk
  always @(negedge clk) begin
    if (read && !waitrequest && exp_q.size() > 0) begin
      compare($sformatf("reg %h", address), exp_q.pop_front(), readdata & msk_q.pop_front());
    end
  end
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial begin
    {rst_n, read, write, sleep_mode, cmp_one, cmp_two} = '0;
    address = 8'h00;
    writedata = 32'h0;
    void'($urandom(85865));
    dir = 2'($urandom);
    pout = 2'($urandom);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(CONTROL_OFFSET, 32'h0, 32'hffffffff);
    rd_chk(FLAGS_OFFSET, 32'h0, 32'h3);
    wr(CONTROL_OFFSET, 32'hff);
    rd_chk(CONTROL_OFFSET, 32'h3f, 32'hffffffff);
    wr(8'h04, 32'hffffffff);
    rd_chk(8'h04, 32'h0, 32'hffffffff);
    wr(CONTROL_OFFSET, 32'h0);
    v = $urandom;
    wr(COUNT_LO_OFFSET, v);
    wr(COUNT_HI_OFFSET, v >> 8);
    rd_chk(COUNT_LO_OFFSET, {24'h0, v[7:0]}, 32'hff);
    rd_chk(COUNT_HI_OFFSET, {24'h0, v[15:8]}, 32'hff);
    // Odd prescale rows also set the sync bit, which timer mode ignores
    for (int ps = 0; ps < 4; ps++) begin
      wr(CONTROL_OFFSET, {24'h0, 2'b00, 2'(ps), 1'b0, ps[0], 2'b01});
      repeat (80) @(posedge clk);
      s1 = cyc;
      rd_chk(COUNT_LO_OFFSET, 32'h0, 32'h0);
      base = rd_val;
      while (cyc != s1 + 32 * (1 << ps)) @(posedge clk);
      rd_chk(COUNT_LO_OFFSET, {24'h0, 8'(base[7:0] + 8'd8)}, 32'hff);
    end
    wr(CONTROL_OFFSET, 32'h0);
    for (int i = 0; i < 5; i++) begin
      wr(COUNT_LO_OFFSET, 32'h0);
      wr(COUNT_HI_OFFSET, 32'h0);
      sleep_mode <= c_slp[i];
      wr(CONTROL_OFFSET, {24'h0, c_ctl[i]});
      i_src.pulse(c_n[i], c_ctl[i][3]);
      i_src.hold_idle_pin(c_ctl[i][3], 1'b1);
      repeat (8) @(posedge clk);
      rd_chk(PIN_OFFSET, c_ctl[i][3] ? 32'h0 : 32'h2, 32'h3);
      compare("osc_inverter_on", {31'h0, c_ctl[i][3]}, {31'h0, osc_on});
      compare("pin_oe", c_ctl[i][3] ? 32'h0 : {30'h0, ~dir}, {30'h0, pin_oe});
      compare("pin_out", {30'h0, pout}, {30'h0, pin_out});
      i_src.hold_idle_pin(c_ctl[i][3], 1'b0);
      wr(CONTROL_OFFSET, 32'h0);
      sleep_mode <= 1'b0;
      rd_chk(COUNT_LO_OFFSET, {24'h0, c_exp[i]}, 32'hff);
    end
    for (int k = 0; k < 2; k++) begin
      wr(COUNT_LO_OFFSET, 32'h55);
      cmp_one <= (k == 0);
      cmp_two <= (k == 1);
      @(posedge clk);
      cmp_one <= 1'b0;
      cmp_two <= 1'b0;
      repeat (6) @(posedge clk);
      rd_chk(COUNT_LO_OFFSET, 32'h0, 32'hff);
    end
    // Second pass clears flag and enable, so the wrap must stay masked
    for (int k = 0; k < 2; k++) begin
      wr(FLAGS_OFFSET, (k == 0) ? 32'h2 : 32'h0);
      wr(COUNT_LO_OFFSET, 32'hfd);
      wr(COUNT_HI_OFFSET, 32'hff);
      wr(CONTROL_OFFSET, 32'h1);
      repeat (40) @(posedge clk);
      wr(CONTROL_OFFSET, 32'h0);
      rd_chk(COUNT_HI_OFFSET, 32'h0, 32'hff);
      rd_chk(FLAGS_OFFSET, (k == 0) ? 32'h3 : 32'h1, 32'h3);
      compare("overflow_irq", (k == 0) ? 32'h1 : 32'h0, {31'h0, irq});
    end
    close_out();
  end
endmodule : timer_one_tb
`default_nettype wire
